// File: option_rom_pkg.sv
// Purpose: shared constants for the option ROM decoder
// Assumes: 16 KB byte-wide program array, option area in its top sixteen bytes
// Notes:   option byte offsets are relative to the first option byte
`default_nettype none
package option_rom_pkg;
   // array geometry
   localparam int          ROM_ADDR_W   = 14;
   localparam int          ROM_BYTES    = 16384;
   localparam int          OPT_IDX_W    = 4;
   localparam int          OPT_COUNT    = 16;
   localparam logic [13:0] OPT_BASE     = 14'h3ff0;
   localparam logic [13:0] OPT_LAST     = 14'h3fff;
   localparam logic [3:0]  OPT_LAST_IDX = 4'hf;
   // option byte offsets
   localparam logic [3:0]  OFS_MAIN     = 4'h0;
   localparam logic [3:0]  OFS_DRV01    = 4'h1;
   localparam logic [3:0]  OFS_DRV23    = 4'h2;
   localparam logic [3:0]  OFS_DRV45    = 4'h3;
   localparam logic [3:0]  OFS_DRV6     = 4'h4;
   localparam logic [3:0]  OFS_DRV8     = 4'h5;
   localparam logic [3:0]  OFS_DRV12    = 4'h7;
   localparam logic [3:0]  OFS_ARRAY    = 4'h8;
   // fields of the main option byte
   localparam int          BIT_WDT      = 0;
   localparam int          BIT_P0_LVL   = 1;
   localparam int          BIT_P1_LVL   = 2;
   localparam int          BIT_P8_LVL   = 3;
   localparam int          BIT_MAIN_OSC = 4;
   localparam int          BIT_SUB_OSC  = 5;
   localparam int          BIT_P4_LVL   = 6;
   localparam int          BIT_P5_LVL   = 7;
   // fields of the array option byte
   localparam int          INV_LSB      = 0;
   localparam int          INV_W        = 5;
   localparam int          BIT_ZC_BUF   = 5;
   localparam int          BIT_BUF      = 6;
   // field widths of the driver bytes
   localparam int          DRV23_W      = 7;
   localparam int          NIB_W        = 4;
   // data values
   localparam logic [7:0]  ERASED_BYTE  = 8'hff;
   localparam logic [7:0]  LOCKED_READ  = 8'h00;
   localparam logic [7:0]  OPT_RESET    = 8'h00;
   // option loader states
   typedef enum logic {LD_FETCH, LD_DONE} load_state_e;
endpackage
`default_nettype wire

// File: option_rom_decoder.sv
// Purpose: program array with option-area loader, option decode and readout lock
// Assumes: programmer pins are asynchronous to clk and held steady around strobes
// Notes:   option outputs are valid once optionsValid is high and cpuResetOut low
//
// Summary of operation
// - options come from the sixteen top bytes of the program array.
// - main byte bit 0 set enables the watchdog, clear omits it.
// - main byte bit 4 picks external clock at 0, ceramic at 1.
// - main byte bit 5 picks sub-clock input port at 0, crystal at 1.
// - main byte bits 6 and 7 give ports four, five reset level, 1 low.
// - main byte bits 1 to 3 give ports zero, one, eight reset level, 1 high.
// - byte eight bits 0 to 4 enable inverter outputs when clear.
// - byte eight bit 5 clear enables the zero-cross bias buffer.
// - once locked, reads never return stored contents.
// - reads during the locking pass make verification fail.
// - a locking pass writing only erased bytes does not lock.
// - reset pin is ignored while the hold input is low.
`timescale 1ns/10ps
`default_nettype none
module option_rom_decoder
   import option_rom_pkg::*;
#(
   parameter int ADDR_W = ROM_ADDR_W,
   parameter int DEPTH  = ROM_BYTES
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // device pins
   input  wire logic              resetPinN,
   input  wire logic              holdPinN,
   // programmer pins
   input  wire logic              progMode,
   input  wire logic              progWrite,
   input  wire logic              progRead,
   input  wire logic [ADDR_W-1:0] progAddr,
   input  wire logic [7:0]        progWrData,
   input  wire logic              readoutLockControl,
   output logic      [7:0]        progRdData,
   output logic                   progRdValid,
   output logic                   lockActive,
   // processor reset and load status
   output logic                   cpuResetOut,
   output logic                   optionsValid,
   // clock and watchdog options
   output logic                   watchdogEnable,
   output logic                   mainClkCeramic,
   output logic                   subOscEnable,
   // reset levels, 1 means high
   output logic                   portZeroResetHigh,
   output logic                   portOneResetHigh,
   output logic                   portFourResetHigh,
   output logic                   portFiveResetHigh,
   output logic                   portEightResetHigh,
   // driver types, 1 means pull-up or cmos
   output logic      [7:0]        portZeroOneDriver,
   output logic      [DRV23_W-1:0] portTwoThreeDriver,
   output logic      [7:0]        portFourFiveDriver,
   output logic      [NIB_W-1:0]  portSixDriver,
   output logic      [NIB_W-1:0]  portTwelveDriver,
   output logic      [NIB_W-1:0]  portEightPullDown,
   // array options, 1 means present
   output logic      [INV_W-1:0]  inverterEnable,
   output logic                   bufferEnable,
   output logic                   zeroCrossBufferEnable
);
   localparam int SYNC_W = ADDR_W + 14;

   // a blank array reads as erased bytes, so the first load never pulls in unknowns
   logic [7:0]        romMem [0:DEPTH-1] = '{default: ERASED_BYTE};
   logic [7:0]        optImage [0:OPT_COUNT-1];
   logic [SYNC_W-1:0] pinMeta;
   logic [SYNC_W-1:0] pinSync;
   logic              wrDly;
   logic              rdDly;
   logic              progModeS;
   logic              wrS;
   logic              rdS;
   logic              lockCtlS;
   logic              resetPinNS;
   logic              holdPinNS;
   logic [ADDR_W-1:0] addrS;
   logic [7:0]        dataS;
   logic              wrStrobe;
   logic              rdStrobe;
   logic              pinResetReq;
   logic [7:0]        storedByte;
   load_state_e       loadState;
   logic [OPT_IDX_W-1:0] loadIdx;
   logic              passWritten;
   logic              passDisqualified;

   // two-stage synchroniser for every pin input
   always_ff @(posedge clk) begin
      pinMeta <= {progMode, progWrite, progRead, readoutLockControl, resetPinN, holdPinN, progAddr, progWrData};
      pinSync <= pinMeta;
   end

   assign {progModeS, wrS, rdS, lockCtlS, resetPinNS, holdPinNS, addrS, dataS} = pinSync;

   // strobe edge detection on synchronised levels
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrDly <= 1'b0;
         rdDly <= 1'b0;
      end else begin
         wrDly <= wrS;
         rdDly <= rdS;
      end
   end

   assign wrStrobe    = progModeS && wrS && !wrDly;
   assign rdStrobe    = progModeS && rdS && !rdDly;
   assign pinResetReq = !resetPinNS && holdPinNS;
   assign storedByte  = romMem[addrS];

   // programmer writes into the array
   always_ff @(posedge clk) begin
      if (wrStrobe) begin
         romMem[addrS] <= dataS;
      end
   end

   // option loader: walks the top sixteen bytes after any reset
   always_ff @(posedge clk) begin
      if (sys_rst || pinResetReq) begin
         loadState <= LD_FETCH;
         loadIdx   <= '0;
         for (int i = 0; i < OPT_COUNT; i++) begin
            optImage[i] <= OPT_RESET;
         end
      end else begin
         unique case (loadState)
            LD_FETCH: begin
               optImage[loadIdx] <= romMem[{OPT_BASE[ADDR_W-1:OPT_IDX_W], loadIdx}];
               loadIdx           <= loadIdx + 1'b1;
               if (loadIdx == OPT_LAST_IDX) begin
                  loadState <= LD_DONE;
               end
            end
            LD_DONE: begin
               loadState <= LD_DONE;
            end
         endcase
      end
   end

   // processor is held in reset until the options are in place
   assign optionsValid = (loadState == LD_DONE);
   assign cpuResetOut  = !optionsValid || pinResetReq;

   // main option byte decode
   assign watchdogEnable     = optImage[OFS_MAIN][BIT_WDT];
   assign mainClkCeramic     = optImage[OFS_MAIN][BIT_MAIN_OSC];
   assign subOscEnable       = optImage[OFS_MAIN][BIT_SUB_OSC];
   assign portFourResetHigh  = !optImage[OFS_MAIN][BIT_P4_LVL];
   assign portFiveResetHigh  = !optImage[OFS_MAIN][BIT_P5_LVL];
   assign portZeroResetHigh  = optImage[OFS_MAIN][BIT_P0_LVL];
   assign portOneResetHigh   = optImage[OFS_MAIN][BIT_P1_LVL];
   assign portEightResetHigh = optImage[OFS_MAIN][BIT_P8_LVL];

   // driver type bytes, one bit per pin in ascending order
   assign portZeroOneDriver  = optImage[OFS_DRV01];
   assign portTwoThreeDriver = optImage[OFS_DRV23][DRV23_W-1:0];
   assign portFourFiveDriver = optImage[OFS_DRV45];
   assign portSixDriver      = optImage[OFS_DRV6][NIB_W-1:0];
   assign portTwelveDriver   = optImage[OFS_DRV12][NIB_W-1:0];
   assign portEightPullDown  = optImage[OFS_DRV8][NIB_W-1:0];

   // inverter and buffer arrays are present when their bit is clear
   assign inverterEnable        = ~optImage[OFS_ARRAY][INV_LSB +: INV_W];
   assign bufferEnable          = !optImage[OFS_ARRAY][BIT_BUF];
   assign zeroCrossBufferEnable = !optImage[OFS_ARRAY][BIT_ZC_BUF];

   // locking pass bookkeeping: a read before any write marks a blank-check pass
   always_ff @(posedge clk) begin
      if (sys_rst || !lockCtlS) begin
         passWritten      <= 1'b0;
         passDisqualified <= 1'b0;
      end else begin
         if (wrStrobe) begin
            passWritten <= 1'b1;
         end
         if (rdStrobe && !passWritten) begin
            passDisqualified <= 1'b1;
         end
      end
   end

   // lock is sticky once a qualifying non-erased write lands
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lockActive <= 1'b0;
      end else if (lockCtlS && wrStrobe && !passDisqualified && (dataS != ERASED_BYTE)) begin
         lockActive <= 1'b1;
      end
   end

   // read port: locked reads are refused, pass reads return inverted data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         progRdData  <= 8'h00;
         progRdValid <= 1'b0;
      end else begin
         progRdValid <= rdStrobe;
         if (rdStrobe) begin
            if (lockActive) begin
               progRdData <= LOCKED_READ;
            end else if (lockCtlS) begin
               progRdData <= ~storedByte;
            end else begin
               progRdData <= storedByte;
            end
         end
      end
   end

   // processor stays in reset for the first eight cycles after a system reset cycle
   property p_reset_holds_cpu;
      @(posedge clk) sys_rst |=> cpuResetOut [*8];
   endproperty
   a_reset_holds_cpu: assert property (p_reset_holds_cpu) else $error("cpu reset released during option load");

   // checker helper: cycles since the last reset of either kind, saturating
   localparam int                    LOAD_CNT_W  = OPT_IDX_W + 1;
   localparam logic [LOAD_CNT_W-1:0] LOAD_CYCLES = LOAD_CNT_W'(OPT_COUNT);
   logic [LOAD_CNT_W-1:0]            quietCount;

   always_ff @(posedge clk) begin
      if (sys_rst || pinResetReq) begin
         quietCount <= '0;
      end else if (quietCount != '1) begin
         quietCount <= quietCount + 1'b1;
      end
   end

   // load finishes after sixteen quiet cycles, counted rather than unrolled
   property p_load_bound;
      @(posedge clk) disable iff (sys_rst) (quietCount >= LOAD_CYCLES) |-> optionsValid;
   endproperty
   a_load_bound: assert property (p_load_bound) else $error("option load did not finish");

   // watchdog, port zero/one driver and inverter options never move once valid
   property p_options_stable;
      @(posedge clk) disable iff (sys_rst) (optionsValid && !pinResetReq) ##1 optionsValid
         |-> $stable(watchdogEnable) && $stable(portZeroOneDriver) && $stable(inverterEnable);
   endproperty
   a_options_stable: assert property (p_options_stable) else $error("option output changed without reset");

   // reset pin has no effect while hold is low
   property p_hold_blocks_reset;
      @(posedge clk) disable iff (sys_rst) (optionsValid && !holdPinNS) |=> optionsValid;
   endproperty
   a_hold_blocks_reset: assert property (p_hold_blocks_reset) else $error("reset accepted while hold low");

   // locked device answers every read with the fixed value
   property p_locked_read;
      @(posedge clk) disable iff (sys_rst) (rdStrobe && lockActive) |=> progRdValid && (progRdData == LOCKED_READ);
   endproperty
   a_locked_read: assert property (p_locked_read) else $error("stored data read while locked");

   // verify reads during the locking pass mismatch the stored byte
   property p_pass_verify_fails;
      @(posedge clk) disable iff (sys_rst) (rdStrobe && lockCtlS && !lockActive)
         |=> progRdValid && (progRdData != $past(storedByte));
   endproperty
   a_pass_verify_fails: assert property (p_pass_verify_fails) else $error("locking pass verify matched");

   // erased-byte writes never lock
   property p_erased_no_lock;
      @(posedge clk) disable iff (sys_rst) (wrStrobe && (dataS == ERASED_BYTE) && !lockActive) |=> !lockActive;
   endproperty
   a_erased_no_lock: assert property (p_erased_no_lock) else $error("erased write activated lock");

   // reset level of port four is the inverse of its bit, port zero's follows its bit
   property p_level_polarity;
      @(posedge clk) disable iff (sys_rst) optionsValid
         |-> (portFourResetHigh != optImage[OFS_MAIN][BIT_P4_LVL]) && (portZeroResetHigh == optImage[OFS_MAIN][BIT_P0_LVL]);
   endproperty
   a_level_polarity: assert property (p_level_polarity) else $error("reset level polarity wrong");

   // main scenarios
   c_load_done:  cover property (@(posedge clk) disable iff (sys_rst) $rose(optionsValid));
   c_lock_set:   cover property (@(posedge clk) disable iff (sys_rst) $rose(lockActive));
   c_pin_reset:  cover property (@(posedge clk) disable iff (sys_rst) optionsValid ##1 pinResetReq);
   c_plain_read: cover property (@(posedge clk) disable iff (sys_rst) rdStrobe && !lockCtlS && !lockActive);
   // a read refused by the lock
   c_lock_read:  cover property (@(posedge clk) disable iff (sys_rst) rdStrobe && lockActive);
endmodule
`default_nettype wire

// File: option_programmer.sv
// Purpose: programmer model driving the parallel programming pins
// Assumes: pins change at the falling edge, write strobe held four clocks, read strobe four
// Notes:   address shows the inverse once a transfer ends, write data once a write ends
`timescale 1ns/10ps
`default_nettype none
module option_programmer (
   // clock
   input  wire logic       clk,
   // programmer pins
   output logic            progMode,
   output logic            progWrite,
   output logic            progRead,
   output logic [13:0]     progAddr,
   output logic [7:0]      progWrData,
   output logic            readoutLockControl,
   // device answer
   input  wire logic [7:0] progRdData,
   input  wire logic       progRdValid
);
   // idle levels, lock control off for normal passes
   initial begin
      progMode = 1'b1;
      progWrite = 1'b0;
      progRead = 1'b0;
      progAddr = 14'h0000;
      progWrData = 8'h00;
      readoutLockControl = 1'b0;
   end

   // wait whole clocks between pin changes
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask

   // change lock control and let the synchroniser see it
   task automatic setLock(input logic on);
      @(negedge clk);
      readoutLockControl = on;
      settle(4);
   endtask

   // one byte write with setup and hold around the strobe
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      @(negedge clk);
      progAddr = a;
      progWrData = d;
      settle(3);
      progWrite = 1'b1;
      settle(4);
      progWrite = 1'b0;
      settle(3);
      progAddr = ~a; // released lines no longer show the last value
      progWrData = ~d;
   endtask

   // one byte read, answer taken at the edge that shows valid
   task automatic rd(input logic [13:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(negedge clk);
      progAddr = a;
      settle(3);
      progRead = 1'b1;
      for (int n = 0; n < 8 && ok == 1'b0; n++) begin
         @(posedge clk);
         #1;
         if (progRdValid === 1'b1) begin
            ok = 1'b1;
            d = progRdData;
         end
      end
      settle(2);
      progRead = 1'b0;
      settle(3);
      progAddr = ~a;
   endtask
endmodule
`default_nettype wire

// File: option_rom_decoder_bench.sv
// Purpose: self-checking bench for the option ROM decoder
// Assumes: inputs change at the falling edge of a 200 MHz clock
// Notes:   option images are table rows; reset pin and lock get hand tests
`timescale 1ns/10ps
`default_nettype none
module option_rom_decoder_bench
   import option_rom_pkg::*;
;
   logic                 clk, sys_rst, resetPinN, holdPinN, progMode, progWrite, progRead;
   logic                 readoutLockControl, progRdValid, lockActive, cpuResetOut, optionsValid;
   logic [13:0]          progAddr;
   logic [7:0]           progWrData, progRdData, portZeroOneDriver, portFourFiveDriver;
   logic                 watchdogEnable, mainClkCeramic, subOscEnable, bufferEnable, zeroCrossBufferEnable;
   logic                 portZeroResetHigh, portOneResetHigh, portFourResetHigh, portFiveResetHigh;
   logic                 portEightResetHigh;
   logic [DRV23_W-1:0]   portTwoThreeDriver;
   logic [NIB_W-1:0]     portSixDriver, portTwelveDriver, portEightPullDown;
   logic [INV_W-1:0]     inverterEnable;
   wire logic [49:0]     optsOut;
   int                   failCount, checksDone;
   // option rows {byte8, byte7, byte5, byte4, byte3, byte2, byte1, byte0}, byte8 bit 7 always set
   localparam logic [63:0] ROWS [4] = '{64'h8000000000000000, 64'hff0f0f0fff7fffff,
                                        64'h950a0609c3355aa5, 64'hea05030c3c4aa55a};

   // all decoded options in one vector
   assign optsOut = {watchdogEnable, mainClkCeramic, subOscEnable, portZeroResetHigh, portOneResetHigh,
                     portFourResetHigh, portFiveResetHigh, portEightResetHigh, portZeroOneDriver,
                     portTwoThreeDriver, portFourFiveDriver, portSixDriver, portTwelveDriver,
                     portEightPullDown, inverterEnable, bufferEnable, zeroCrossBufferEnable};

   option_rom_decoder option_rom_decoder_i (.clk, .sys_rst, .resetPinN, .holdPinN, .progMode, .progWrite,
      .progRead, .progAddr, .progWrData, .readoutLockControl, .progRdData, .progRdValid, .lockActive,
      .cpuResetOut, .optionsValid, .watchdogEnable, .mainClkCeramic, .subOscEnable, .portZeroResetHigh,
      .portOneResetHigh, .portFourResetHigh, .portFiveResetHigh, .portEightResetHigh, .portZeroOneDriver,
      .portTwoThreeDriver, .portFourFiveDriver, .portSixDriver, .portTwelveDriver, .portEightPullDown,
      .inverterEnable, .bufferEnable, .zeroCrossBufferEnable);

   option_programmer option_programmer_i (.clk, .progMode, .progWrite, .progRead, .progAddr, .progWrData,
      .readoutLockControl, .progRdData, .progRdValid);

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // byte written at each option offset
   function automatic logic [7:0] imgByte(input logic [63:0] r, input int o);
      if (o < 6) return r[8*o +: 8];
      if (o == 7 || o == 8) return r[8*(o-1) +: 8];
      return 8'h00;
   endfunction

   // expected decode of one row
   function automatic logic [49:0] expOpts(input logic [63:0] r);
      logic [7:0] m, a;
      m = r[7:0];
      a = r[63:56];
      return {m[0], m[4], m[5], m[1], m[2], ~m[6], ~m[7], m[3], r[15:8], r[22:16], r[31:24], r[35:32],
              r[51:48], r[43:40], ~a[4:0], ~a[6], ~a[5]};
   endfunction

   task automatic closeOut();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cmpVal(input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmpOpts(input logic [49:0] got, input logic [49:0] exp);
      checksDone++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // bounded wait for the option load to finish
   task automatic waitLoad();
      int n;
      for (n = 0; n < 40 && optionsValid !== 1'b1; n++) @(negedge clk);
      if (n == 40) begin
         failCount++;
         closeOut();
      end
      cmpVal({7'h00, cpuResetOut}, 8'h00);
   endtask

   // hold system reset, check the held state, then reload
   task automatic resetFor(input int n);
      sys_rst = 1'b1;
      repeat (n) @(negedge clk);
      cmpVal({6'h00, optionsValid, lockActive}, 8'h00);
      cmpVal({7'h00, cpuResetOut}, 8'h01);
      sys_rst = 1'b0;
      waitLoad();
   endtask

   task automatic rdCmp(input logic [13:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      option_programmer_i.rd(a, d, ok);
      if (ok !== 1'b1) begin
         failCount++;
         closeOut();
      end
      cmpVal(d, exp);
   endtask

   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      failCount++;
      closeOut();
   end

   // main sequence
   initial begin
      resetPinN = 1'b1;
      holdPinN = 1'b1;
      failCount = 0;
      checksDone = 0;
      resetFor(12);
      for (int r = 0; r < 4; r++) begin
         for (int o = 0; o < OPT_COUNT; o++) begin
            option_programmer_i.wr(OPT_BASE + 14'(o), imgByte(ROWS[r], o));
         end
         resetFor(3);
         cmpOpts(optsOut, expOpts(ROWS[r]));
      end
      // a later write stays hidden until the next load
      option_programmer_i.wr(OPT_BASE, 8'h01);
      cmpOpts(optsOut, expOpts(ROWS[3]));
      // reset pin is ignored while hold is low
      holdPinN = 1'b0;
      repeat (4) @(negedge clk);
      resetPinN = 1'b0;
      repeat (6) @(negedge clk);
      cmpVal({6'h00, cpuResetOut, optionsValid}, 8'h01);
      holdPinN = 1'b1;
      repeat (6) @(negedge clk);
      cmpVal({7'h00, cpuResetOut}, 8'h01);
      resetPinN = 1'b1;
      waitLoad();
      cmpOpts(optsOut, expOpts({ROWS[3][63:8], 8'h01}));
      // readout lock: disqualified pass, erased-only writes, then a real lock
      rdCmp(14'h3ff8, 8'hea);
      option_programmer_i.setLock(1'b1);
      rdCmp(14'h3ff8, 8'h15);
      option_programmer_i.wr(14'h0010, 8'h5a);
      cmpVal({7'h00, lockActive}, 8'h00);
      option_programmer_i.setLock(1'b0);
      option_programmer_i.setLock(1'b1);
      option_programmer_i.wr(14'h0020, ERASED_BYTE);
      cmpVal({7'h00, lockActive}, 8'h00);
      option_programmer_i.wr(14'h0030, 8'h3c);
      cmpVal({7'h00, lockActive}, 8'h01);
      option_programmer_i.setLock(1'b0);
      rdCmp(14'h0010, LOCKED_READ);
      closeOut();
   end
endmodule
`default_nettype wire
